// ==== rtl/pre_echo_attenuator_regs.vh ====
// constants for the pre-echo attenuator: frame geometry, thresholds, gains
// assumes 16-bit signed samples and a 320-sample frame with 40-sample blocks
`ifndef PRE_ECHO_ATTENUATOR_REGS_VH
`define PRE_ECHO_ATTENUATOR_REGS_VH

// ----------------------------------------------------------------
// frame geometry
// ----------------------------------------------------------------
`define FRAME_LEN 9'd320
// seven thirty-seconds of the frame length
`define MEM_LEN 9'd70
`define LAST_IN_IDX (`FRAME_LEN + `MEM_LEN - 9'd1)
`define BLOCK_COUNT 4'd8
`define BLOCK_LEN 7'd40
`define HALF_LEN 7'd20
`define TQ_LEN 7'd30

// ----------------------------------------------------------------
// activation and classification thresholds
// ----------------------------------------------------------------
`define RATE_LIMIT_KBPS 8'd32
`define ECHO_RATIO_SHIFT 4
`define DEEP_RATIO_SHIFT 5
`define HB_FACTOR 48'd100
`define NOISE_FLOOR 48'd500000
`define ZCR_LIM_NB 7'd10
`define ZCR_LIM_WB 7'd16
// frame length over 24, rounded down
`define RUN_LIMIT 9'd13

// ----------------------------------------------------------------
// gains, unsigned with 14 fraction bits
// ----------------------------------------------------------------
`define GAIN_SHIFT 14
`define GAIN_UNITY 16'h4000
`define GAIN_LIGHT 16'h0666
`define GAIN_DEEP 16'h00a4
`define CODE_UNITY 2'h0
`define CODE_LIGHT 2'h1
`define CODE_DEEP 2'h2

`endif

// ==== rtl/band_split.v ====
// three-tap two-band split of one sample, results scaled by four
// assumes the caller supplies the neighbours and says if a right tap exists
`timescale 1ns/1ns
`default_nettype none

module band_split (
  // taps
  input wire signed [15:0] left,
  input wire signed [15:0] center,
  input wire signed [15:0] right,
  input wire hasRight,
  // bands, four times the true value so no fraction bit is lost
  output wire signed [17:0] lowBand4,
  output wire signed [17:0] highBand4
);

  wire signed [17:0] leftExt;
  wire signed [17:0] centerTwice;
  wire signed [17:0] centerFour;
  wire signed [17:0] rightExt;

  assign leftExt = {{2{left[15]}}, left};
  assign centerTwice = {center[15], center, 1'b0};
  assign centerFour = {center, 2'b00};
  // the right tap drops out at the edge of a segment
  assign rightExt = hasRight ? {{2{right[15]}}, right} : 18'h00000;
  assign lowBand4 = leftExt + centerTwice + rightExt;
  // high band is full band minus low band, weights -0.25 0.5 -0.25
  assign highBand4 = centerFour - lowBand4;

endmodule

`default_nettype wire

// ==== rtl/pre_echo_attenuator.v ====
// frame pre-echo detector and attenuator with one frame of latency
// assumes one clock, frames marked by inFirst, memory samples after each frame
`timescale 1ns/1ns
`default_nettype none
`include "pre_echo_attenuator_regs.vh"

module pre_echo_attenuator (
  // clock and reset
  input wire clk,
  input wire rst_b,
  // overlap-added frame then memory samples in
  input wire inValid,
  input wire signed [15:0] inData,
  input wire inFirst,
  output reg inReady,
  // frame status, taken with the first sample
  input wire frameGood,
  input wire prevGood,
  input wire [7:0] bitrateKbps,
  input wire narrowband,
  // attenuated frame out
  output reg outValid,
  output reg signed [15:0] outData,
  output reg outFirst,
  output reg outLast,
  output reg [3:0] onsetIndex
);

  // ----------------------------------------------------------------
  // state and storage
  // ----------------------------------------------------------------
  localparam S_COLLECT = 3'd0;
  localparam S_FLUSH = 3'd1;
  localparam S_PEAK = 3'd2;
  localparam S_CLASS = 3'd3;
  localparam S_DONE = 3'd4;

  reg [2:0] state;
  reg [8:0] cnt;
  reg [3:0] blk;
  reg [6:0] pos;
  reg [8:0] prevP;
  reg [3:0] prevBlk;
  reg [6:0] prevPos;
  reg signed [15:0] prevS;
  reg signed [15:0] prev2;
  reg signed [15:0] lastSample;
  reg signed [15:0] frameLeft;
  reg signed [15:0] outPrev;
  reg bank;
  reg outBank;
  reg activeFlag;
  reg nbFlag;
  reg [8:0] runLen;
  reg [3:0] runBlk;
  reg [3:0] iter;
  reg [39:0] peakE;
  reg [3:0] peakIdx;
  reg refValid;
  reg [39:0] refE;
  reg [39:0] priorMean;
  reg outRun;
  reg [8:0] outIdx;
  reg [2:0] outBlk;
  reg [5:0] outPos;
  integer k;
  // one loop variable per process so none has two drivers
  integer kData;
  integer kCtl;

  // two banks so one frame drains while the next one fills
  reg signed [15:0] frameStore [0:639];
  reg [39:0] energy [0:8];
  reg [39:0] hbE [0:8];
  reg [39:0] halfE [0:7];
  reg [39:0] tqE [0:7];
  reg [6:0] zcr [0:8];
  reg [8:0] maxRun [0:7];
  reg [1:0] outGain [0:7];

  function [15:0] gainValue;
    input [1:0] code;
    begin
      case (code)
        `CODE_LIGHT: gainValue = `GAIN_LIGHT;
        `CODE_DEEP: gainValue = `GAIN_DEEP;
        default: gainValue = `GAIN_UNITY;
      endcase
    end
  endfunction

  // ----------------------------------------------------------------
  // input side analysis terms
  // ----------------------------------------------------------------
  wire accept = inValid && inReady && (inFirst || cnt != 9'h000);
  wire [8:0] p = inFirst ? 9'h000 : cnt;
  wire isMem = p >= `FRAME_LEN;
  wire [3:0] curBlk = inFirst ? 4'h0 : blk;
  wire [6:0] curPos = inFirst ? 7'h00 : pos;
  wire [9:0] wrAddr = bank ? {1'b0, p} + {1'b0, `FRAME_LEN} : {1'b0, p};
  wire signed [31:0] sampleSq = inData * inData;
  wire signed [31:0] crossProd = prevS * inData;
  wire crossing = p != 9'h000 && (crossProd[31] || ~|crossProd);
  wire [39:0] sqExt = {8'h00, sampleSq};

  // the pending sample prevS gets its high band once its right tap arrives
  wire signed [15:0] leftA = (prevP == 9'h000) ? frameLeft : prev2;
  wire hasRightA = state == S_COLLECT && p != `FRAME_LEN;
  wire signed [17:0] hbA;
  wire hbValid = (accept && p != 9'h000) || state == S_FLUSH;
  wire signed [35:0] hbProd = hbA * hbA;
  wire [39:0] hbSq = {8'h00, hbProd[35:4]};

  band_split splitIn (
    .left(leftA),
    .center(prevS),
    .right(inData),
    .hasRight(hasRightA),
    .lowBand4(),
    .highBand4(hbA)
  );

  // ----------------------------------------------------------------
  // classification terms for block iter
  // ----------------------------------------------------------------
  wire [2:0] ci = iter[2:0];
  wire [39:0] eCur = energy[ci];
  wire [40:0] halfAdj = ({halfE[ci], 1'b0} < {1'b0, eCur}) ?
    {eCur - halfE[ci], 1'b0} : {1'b0, eCur};
  wire [40:0] hbRel = ({1'b0, hbE[ci]} > halfAdj) ? {1'b0, hbE[ci]} : halfAdj;
  wire [47:0] noiseRef = ({8'h00, priorMean} + `NOISE_FLOOR) * `HB_FACTOR;
  wire hbBig = {7'h00, hbRel} > noiseRef;
  wire [6:0] zLim = nbFlag ? `ZCR_LIM_NB : `ZCR_LIM_WB;
  wire zLow = zcr[ci] < zLim;
  wire zQuiet = zcr[ci] < {1'b0, zLim[6:1]};
  wire tqLow = {tqE[ci], 2'b00} + {1'b0, tqE[ci], 1'b0} < {2'b00, eCur};
  wire runLong = maxRun[ci] > `RUN_LIMIT;
  wire cand = activeFlag && iter < peakIdx &&
    {4'h0, peakE} > (eCur << `ECHO_RATIO_SHIFT);
  wire exc = hbBig && (zLow || tqLow);
  wire follow = refValid && {eCur, 1'b0} > {1'b0, refE};
  wire deep = {5'h00, peakE} > (eCur << `DEEP_RATIO_SHIFT);
  wire [1:0] classCode = (!cand || exc || follow || zQuiet || runLong) ?
    `CODE_UNITY : (deep ? `CODE_DEEP : `CODE_LIGHT);

  reg [42:0] sumAll;
  reg [42:0] sumHigh;
  always @*
  begin
    sumAll = 43'h0;
    sumHigh = 43'h0;
    for (k = 0; k < 8; k = k + 1)
    begin
      sumAll = sumAll + {3'h0, energy[k]};
      if (k >= 4)
        sumHigh = sumHigh + {3'h0, energy[k]};
    end
  end
  wire [39:0] meanAll = sumAll[42:3];
  wire [39:0] meanHigh = sumHigh[41:2];

  // ----------------------------------------------------------------
  // output side: split, scale, recombine
  // ----------------------------------------------------------------
  wire [9:0] rdC = outBank ? {1'b0, outIdx} + {1'b0, `FRAME_LEN} :
    {1'b0, outIdx};
  wire [9:0] rdR = rdC + 10'h001;
  wire hasRightB = outIdx != `FRAME_LEN - 9'd1;
  wire signed [15:0] centerB = frameStore[rdC];
  wire signed [15:0] rightB = frameStore[rdR];
  wire signed [17:0] lbB;
  wire signed [17:0] hbB;
  wire signed [16:0] gS = {1'b0, gainValue(outGain[outBlk])};
  wire signed [34:0] lbScaled = lbB * gS;
  wire signed [34:0] hbScaled = hbB * gS;
  wire signed [35:0] mix = {lbScaled[34], lbScaled} +
    {hbScaled[34], hbScaled};
  // drop the gain fraction and the factor four of the split
  wire signed [19:0] mixShift = mix[35:`GAIN_SHIFT + 2];
  wire signed [15:0] mixSat = (mixShift > 20'sh07fff) ? 16'sh7fff :
    (mixShift < -20'sh08000) ? -16'sh8000 : mixShift[15:0];

  band_split splitOut (
    .left(outPrev),
    .center(centerB),
    .right(rightB),
    .hasRight(hasRightB),
    .lowBand4(lbB),
    .highBand4(hbB)
  );

  // ----------------------------------------------------------------
  // data arrays, no reset needed: each entry restarts at its block start, except maxRun, which clears at the frame start
  // ----------------------------------------------------------------
  always @(posedge clk)
  begin
    if (accept)
    begin
      if (!isMem)
        frameStore[wrAddr] <= inData;
      energy[curBlk] <= (curPos == 7'h00 ? 40'h0 : energy[curBlk]) +
        sqExt;
      if (!isMem && curPos < `HALF_LEN)
        halfE[curBlk[2:0]] <= (curPos == 7'h00 ? 40'h0 :
          halfE[curBlk[2:0]]) + sqExt;
      if (!isMem && curPos < `TQ_LEN)
        tqE[curBlk[2:0]] <= (curPos == 7'h00 ? 40'h0 :
          tqE[curBlk[2:0]]) + sqExt;
      zcr[curBlk] <= (curPos == 7'h00 ? 7'h00 : zcr[curBlk]) +
        {6'h00, crossing};
      if (inFirst)
      begin
        for (kData = 0; kData < 8; kData = kData + 1)
          maxRun[kData] <= 9'h000;
      end
      else if (crossing && runBlk < `BLOCK_COUNT &&
        runLen > maxRun[runBlk[2:0]])
        maxRun[runBlk[2:0]] <= runLen;
    end
    if (state == S_FLUSH && runBlk < `BLOCK_COUNT &&
      runLen > maxRun[runBlk[2:0]])
      maxRun[runBlk[2:0]] <= runLen;
    if (hbValid)
      hbE[prevBlk] <= (prevPos == 7'h00 ? 40'h0 : hbE[prevBlk]) +
        hbSq;
  end

  // ----------------------------------------------------------------
  // control
  // ----------------------------------------------------------------
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state <= S_COLLECT;
      inReady <= 1'b1;
      cnt <= 9'h000;
      blk <= 4'h0;
      pos <= 7'h00;
      prevP <= 9'h000;
      prevBlk <= 4'h0;
      prevPos <= 7'h00;
      prevS <= 16'sh0000;
      prev2 <= 16'sh0000;
      lastSample <= 16'sh0000;
      frameLeft <= 16'sh0000;
      outPrev <= 16'sh0000;
      bank <= 1'b0;
      outBank <= 1'b0;
      activeFlag <= 1'b0;
      nbFlag <= 1'b0;
      runLen <= 9'h000;
      runBlk <= 4'h0;
      iter <= 4'h0;
      peakE <= 40'h0;
      peakIdx <= 4'h0;
      refValid <= 1'b0;
      refE <= 40'h0;
      priorMean <= 40'h0;
      outRun <= 1'b0;
      outIdx <= 9'h000;
      outBlk <= 3'h0;
      outPos <= 6'h00;
      outValid <= 1'b0;
      outData <= 16'sh0000;
      outFirst <= 1'b0;
      outLast <= 1'b0;
      onsetIndex <= 4'h0;
      for (kCtl = 0; kCtl < 8; kCtl = kCtl + 1)
        outGain[kCtl] <= `CODE_UNITY;
    end
    else
    begin
      // output engine runs while the next frame is collected
      outValid <= outRun;
      outFirst <= outRun && outIdx == 9'h000;
      outLast <= outRun && !hasRightB;
      if (outRun)
      begin
        outData <= mixSat;
        outPrev <= centerB;
        outIdx <= outIdx + 9'h001;
        if (outPos == `BLOCK_LEN - 7'd1)
        begin
          outPos <= 6'h00;
          outBlk <= outBlk + 3'h1;
        end
        else
          outPos <= outPos + 6'h01;
        if (!hasRightB)
          outRun <= 1'b0;
      end
      case (state)
        S_COLLECT:
        begin
          if (accept)
          begin
            if (inFirst)
            begin
              frameLeft <= lastSample;
              activeFlag <= frameGood && prevGood &&
                bitrateKbps <= `RATE_LIMIT_KBPS;
              nbFlag <= narrowband;
            end
            if (p == `FRAME_LEN - 9'd1)
              lastSample <= inData;
            prevS <= inData;
            prev2 <= prevS;
            prevP <= p;
            prevBlk <= curBlk;
            prevPos <= curPos;
            if (curBlk < `BLOCK_COUNT && curPos == `BLOCK_LEN - 7'd1)
            begin
              blk <= curBlk + 4'h1;
              pos <= 7'h00;
            end
            else
            begin
              blk <= curBlk;
              pos <= curPos + 7'h01;
            end
            if (p == 9'h000 || crossing)
            begin
              runLen <= 9'h001;
              runBlk <= curBlk;
            end
            else
              runLen <= runLen + 9'h001;
            if (p == `LAST_IN_IDX)
            begin
              cnt <= 9'h000;
              inReady <= 1'b0;
              state <= S_FLUSH;
            end
            else
              cnt <= p + 9'h001;
          end
        end
        S_FLUSH:
        begin
          iter <= 4'h0;
          peakE <= 40'h0;
          peakIdx <= 4'h0;
          state <= S_PEAK;
        end
        S_PEAK:
        begin
          // strict compare keeps the first of equal peaks
          if (iter == 4'h0 || energy[iter] > peakE)
          begin
            peakE <= energy[iter];
            peakIdx <= iter;
          end
          if (iter == `BLOCK_COUNT)
          begin
            iter <= `BLOCK_COUNT - 4'h1;
            refValid <= 1'b0;
            state <= S_CLASS;
          end
          else
            iter <= iter + 4'h1;
        end
        S_CLASS:
        begin
          // walk back from the last block so a non-echo block pulls in earlier ones
          outGain[ci] <= classCode;
          if (cand && exc)
          begin
            refValid <= 1'b1;
            refE <= eCur;
          end
          if (iter == 4'h0)
            state <= S_DONE;
          else
            iter <= iter - 4'h1;
        end
        S_DONE:
        begin
          priorMean <= (meanAll > meanHigh) ? meanAll : meanHigh;
          onsetIndex <= peakIdx;
          outBank <= bank;
          bank <= ~bank;
          outRun <= 1'b1;
          outIdx <= 9'h000;
          outBlk <= 3'h0;
          outPos <= 6'h00;
          outPrev <= frameLeft;
          inReady <= 1'b1;
          state <= S_COLLECT;
        end
        default:
          state <= S_COLLECT;
      endcase
    end
  end

endmodule

`default_nettype wire

// ==== tb/pre_echo_attenuator_asserts.sv ====
// port checker for the pre-echo attenuator
// assumes binding onto the top module; one clock domain
`timescale 1ns/1ns
`default_nettype none
module pre_echo_attenuator_checker (
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // streams
  input wire logic inValid,
  input wire logic inFirst,
  input wire logic inReady,
  input wire logic outValid,
  input wire logic outFirst,
  input wire logic outLast,
  input wire logic [3:0] onsetIndex
);
  logic [8:0] inCnt;
  logic [8:0] outCnt;
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);
  // ----------------------------------------
  // sample counters; inFirst restarts the input count
  // ----------------------------------------
  always @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      inCnt <= 9'h000;
      outCnt <= 9'h000;
    end
    else
    begin
      if (inValid && inReady)
        inCnt <= inFirst ? 9'h001 : (inCnt == 9'h000 || inCnt == 9'h185)
          ? 9'h000 : inCnt + 9'h001;
      if (outValid)
        outCnt <= outFirst ? 9'h001 : outCnt + 9'h001;
    end
  end
  // ----------------------------------------
  // properties
  // ----------------------------------------
  reset_idle_a: assert property ($rose(rst_b) |-> inReady
    && !outValid && !outFirst) else $error("outputs busy after reset");
  first_opens_a: assert property (outFirst |-> outValid
    && !$past(outValid)) else $error("first output not at run start");
  last_count_a: assert property (outLast |-> outValid
    && outCnt == 9'h13f) else $error("last output not sample 319");
  run_inside_a: assert property (outValid && !outFirst |->
    outCnt != 9'h000 && outCnt < 9'h140) else $error("output run broken");
  run_gapless_a: assert property ($fell(outValid) |->
    $past(outLast)) else $error("output run ended early");
  ready_drop_a: assert property (inValid && inReady && !inFirst
    && inCnt == 9'h185 |=> !inReady) else $error("ready after sample 389");
  ready_back_a: assert property ($fell(inReady) |->
    ##[1:40] inReady) else $error("input stayed refused");
  out_start_a: assert property ($rose(inReady) |->
    ##[0:4] outFirst) else $error("no output after frame done");
  onset_range_a: assert property (outValid |->
    onsetIndex <= 4'h8 && (outFirst || $stable(onsetIndex)))
    else $error("onset index out of range or moving");
  cover property (outFirst && onsetIndex == 4'h8);
  cover property (outFirst && onsetIndex == 4'h0);
  cover property ($fell(inReady));
endmodule
bind pre_echo_attenuator pre_echo_attenuator_checker i_chk (.clk(clk),
  .rst_b(rst_b), .inValid(inValid), .inFirst(inFirst), .inReady(inReady),
  .outValid(outValid), .outFirst(outFirst), .outLast(outLast),
  .onsetIndex(onsetIndex));
`default_nettype wire

// ==== tb/overlap_add_source.sv ====
// model of the overlap-add stage feeding the attenuator
// assumes the bench fills mem and calls send_frame at a rising edge
`timescale 1ns/1ns
`default_nettype none
module overlap_add_source (
  // clock
  input wire logic clk,
  // sample handshake
  input wire logic inReady,
  output logic inValid,
  output logic signed [15:0] inData,
  output logic inFirst,
  // frame status
  output logic frameGood,
  output logic prevGood,
  output logic [7:0] bitrateKbps,
  output logic narrowband,
  output logic stuck
);
  // overlap-added frame then un-windowed memory samples
  logic signed [15:0] mem [0:389];
  initial
  begin
    inValid = 1'b0;
    inData = 16'h0000;
    inFirst = 1'b0;
    frameGood = 1'b0;
    prevGood = 1'b0;
    bitrateKbps = 8'h00;
    narrowband = 1'b0;
    stuck = 1'b0;
  end
  task automatic send_frame(input logic fg, input logic pg, input logic nb,
    input logic [7:0] rate, input logic slow);
    int i;
    int w;
    // a stuck handshake abandons the rest so a hang cannot run for long
    for (i = 0; i < 390 && !stuck; i++)
    begin
      inValid <= 1'b1;
      inData <= mem[i];
      inFirst <= i == 0;
      frameGood <= fg;
      prevGood <= pg;
      bitrateKbps <= rate;
      narrowband <= nb;
      w = 0;
      do
      begin
        @(posedge clk);
        w++;
      end
      while (!inReady && w < 100);
      if (w >= 100)
        stuck = 1'b1;
      if (slow && i % 7 == 3)
      begin
        // a released data line never keeps the old value
        inValid <= 1'b0;
        inData <= ~mem[i];
        @(posedge clk);
      end
    end
    inValid <= 1'b0;
    inFirst <= 1'b0;
    inData <= ~mem[389];
    // let an edge pass so the next frame never re-raises valid at once
    @(posedge clk);
  endtask
endmodule
`default_nettype wire

// ==== tb/pre_echo_attenuator_tb.sv ====
// self-checking bench for the pre-echo attenuator
// assumes the source model and the bound checker; quiet blocks keep their
// high-band energy below the exception floor and their runs short
`timescale 1ns/1ns
`default_nettype none
`include "pre_echo_attenuator_regs.vh"
`define CHECK(got, want) \
  begin \
    samples_checked++; \
    if ((got) !== (want)) \
    begin \
      n_mismatch++; \
      $display("[ERR] %0t got %0h want %0h", $time, got, want); \
    end \
  end
module pre_echo_attenuator_tb;
  logic clk;
  logic rst_b;
  wire inValid, inFirst, inReady, frameGood, prevGood, narrowband, stuck;
  wire outValid, outFirst, outLast;
  wire signed [15:0] inData, outData;
  wire [7:0] bitrateKbps;
  wire [3:0] onsetIndex;
  int n_mismatch = 0;
  int samples_checked = 0;
  int oIdx = 0;
  int w;
  logic [31:0] rngState = 32'hbe69;
  logic signed [15:0] expQ [$];
  logic [3:0] onQ [$];
  logic signed [15:0] want;
  logic [3:0] wantOn;
  overlap_add_source i_up (.clk(clk), .inReady(inReady), .inValid(inValid),
    .inData(inData), .inFirst(inFirst), .frameGood(frameGood),
    .prevGood(prevGood), .bitrateKbps(bitrateKbps),
    .narrowband(narrowband), .stuck(stuck));
  pre_echo_attenuator i_dut (.clk(clk), .rst_b(rst_b), .inValid(inValid),
    .inData(inData), .inFirst(inFirst), .inReady(inReady),
    .frameGood(frameGood), .prevGood(prevGood), .bitrateKbps(bitrateKbps),
    .narrowband(narrowband), .outValid(outValid), .outData(outData),
    .outFirst(outFirst), .outLast(outLast), .onsetIndex(onsetIndex));
  initial
  begin
    clk = 1'b0;
    forever #2 clk = ~clk;
  end
  function automatic logic [31:0] rnd();
    rngState ^= rngState << 13;
    rngState ^= rngState >> 17;
    rngState ^= rngState << 5;
    return rngState;
  endfunction
  // ----------------------------------------
  // frame builder: loud frame blocks at on and on+1 (memory block if on is 8), light block lt, six-run sx
  // ----------------------------------------
  task automatic run_frame(input int on, input int lt, input int sx,
    input logic nb, input logic fg, input logic pg, input logic [7:0] rate,
    input logic slow);
    longint e [0:8];
    int z [0:7];
    longint pk;
    int n, k, a, x, px, g, onset;
    logic neg;
    for (n = 0; n < 390; n++)
    begin
      k = n < 320 ? n / 40 : 8;
      a = (n < 320 ? k >= on && k <= on + 1 : on == 8) ? 5000
        : k == lt ? 1000 : 1 + rnd() % 150;
      neg = k == sx ? (n % 40) / 6 % 2 == 0 : n % 2 == 1;
      x = neg ? -a : a;
      i_up.mem[n] = 16'(x);
      e[k] += longint'(x) * x;
      if (n >= 1 && n < 320 && px * x <= 0)
        z[k]++;
      px = x;
    end
    onset = 0;
    pk = e[0];
    for (n = 1; n < 9; n++)
      if (e[n] > pk)
      begin
        pk = e[n];
        onset = n;
      end
    onQ.push_back(4'(onset));
    for (n = 0; n < 320; n++)
    begin
      k = n / 40;
      g = `GAIN_UNITY;
      if (fg && pg && rate <= `RATE_LIMIT_KBPS && k < onset
        && pk > 16 * e[k] && z[k] >= (nb ? 5 : 8))
        g = pk > 32 * e[k] ? `GAIN_DEEP : `GAIN_LIGHT;
      expQ.push_back(16'((int'(i_up.mem[n]) * g) >>> 14));
    end
    i_up.send_frame(fg, pg, nb, rate, slow);
    `CHECK(stuck, 1'b0);
    $display("frame with onset %0d done", onset);
  endtask
  task print_verdict;
    $display("checks %0d mismatches %0d", samples_checked, n_mismatch);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  // ----------------------------------------
  // output monitor
  // ----------------------------------------
  always @(posedge clk)
  begin
    if (rst_b && outValid)
    begin
      `CHECK(expQ.size() > 0, 1'b1);
      want = expQ.pop_front();
      `CHECK(outData, want);
      `CHECK(outFirst, oIdx == 0);
      `CHECK(outLast, oIdx == 319);
      if (outFirst)
      begin
        wantOn = onQ.pop_front();
        `CHECK(onsetIndex, wantOn);
      end
      oIdx = outLast ? 0 : oIdx + 1;
    end
  end
  initial
  begin
    rst_b = 1'b0;
    repeat (12) @(posedge clk);
    rst_b <= 1'b1;
    @(posedge clk);
    run_frame(4, 9, 9, 0, 1, 1, 8'd32, 0);
    run_frame(4, 2, 9, 0, 1, 1, 8'd32, 1);
    run_frame(5, 9, 1, 1, 1, 1, 8'd20, 0);
    run_frame(5, 9, 1, 0, 1, 1, 8'd20, 0);
    run_frame(0, 9, 9, 0, 1, 1, 8'd32, 0);
    run_frame(8, 9, 9, 0, 1, 1, 8'd32, 1);
    run_frame(3, 9, 9, 0, 0, 1, 8'd32, 0);
    run_frame(3, 9, 9, 0, 1, 0, 8'd32, 0);
    run_frame(3, 9, 9, 0, 1, 1, 8'd33, 0);
    for (int r = 0; r < 4; r++)
      run_frame(rnd() % 9, rnd() % 8, rnd() % 8, rnd() % 2, 1,
        rnd() % 4 != 0, 8'(rnd() % 34), rnd() % 2);
    w = 0;
    while (expQ.size() > 0 && w < 2000)
    begin
      @(posedge clk);
      w++;
    end
    `CHECK(expQ.size(), 0);
    print_verdict();
  end
endmodule
`default_nettype wire
